// File: common/tlbtap_pkg.sv
package tlbtap_pkg;

   // bus geometry
   localparam int HADDR_W = 32;
   localparam int HDATA_W = 32;
   localparam int DEC_W = 8;
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_DATA = 8'h04;
   localparam logic [1:0] HTRANS_NONSEQ_BIT_SET = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;

   // array geometry
   localparam int PAGE_W = 20;
   localparam int L1_DEPTH = 16;
   localparam int L1_IDX_W = 4;
   localparam int L2_WAYS = 6;
   localparam int L2_SETS = 64;
   localparam int L2_IDX_W = 6;
   localparam int SET_W = 3;
   localparam logic [2:0] L2_LAST_WAY = 3'h5;

   // command register fields
   localparam int LA_MSB = 31;
   localparam int LA_LSB = 12;
   localparam int L1_IDX_MSB = 15;
   localparam int L2_IDX_MSB = 17;
   localparam int CMD_VALID_BIT = 11;
   localparam int CMD_DIRTY_BIT = 10;
   localparam int CMD_GLOBAL_BIT = 9;
   localparam int CMD_USER_BIT = 8;
   localparam int CMD_WPROT_BIT = 6;
   localparam int CMD_ACC_BIT = 5;
   localparam int CMD_MSB = 2;
   localparam int CMD_LSB = 0;
   localparam int CMD_PORT_BIT = 2;
   localparam int CMD_RD_BIT = 1;
   localparam int CMD_LVL_BIT = 0;

   // data register fields
   localparam int PA_MSB = 31;
   localparam int PA_LSB = 12;
   localparam int DAT_CD_BIT = 11;
   localparam int DAT_WT_BIT = 10;
   localparam int SET_MSB = 9;
   localparam int SET_LSB = 7;
   localparam int L1_HIT_BIT = 5;
   localparam int L2_HIT_BIT = 4;
   localparam int HIT_WAY_MSB = 2;
   localparam int HIT_WAY_LSB = 0;

   // software-writable bits and reset values
   localparam logic [31:0] CMD_WR_MASK = 32'hFFFF_FF67;
   localparam logic [31:0] DATA_WR_MASK = 32'hFFFF_FF80;
   localparam logic [31:0] CMD_RST = 32'h0000_0000;
   localparam logic [31:0] DATA_RST = 32'h0000_0000;

   typedef struct packed {
      logic [PAGE_W-1:0] linAddr;
      logic valid;
      logic dirty;
      logic globalPage;
      logic user;
      logic writeProt;
      logic accessed;
      logic [PAGE_W-1:0] physAddr;
      logic cacheDis;
      logic writeThru;
   } tlbtap_entry_s;

   typedef enum {OP_WR_L1, OP_WR_L2, OP_RD_L1, OP_RD_L2} tlbtap_op_e;
   typedef enum {ST_IDLE, ST_EXEC} tlbtap_state_e;

   function automatic tlbtap_op_e tlbtap_decode(input logic [2:0] cmd);
      tlbtap_op_e op;
      if (!cmd[CMD_RD_BIT]) begin
         op = cmd[CMD_LVL_BIT] ? OP_WR_L2 : OP_WR_L1;
      end else begin
         op = cmd[CMD_LVL_BIT] ? OP_RD_L2 : OP_RD_L1;
      end
      return op;
   endfunction : tlbtap_decode

endpackage : tlbtap_pkg

// File: common/tlbtap_array_if.sv
`timescale 1ns/1ps
interface tlbtap_array_if #(parameter int IDX_W = 4);
   import tlbtap_pkg::*;
   logic writeEn;
   logic [IDX_W-1:0] index;
   tlbtap_entry_s writeEntry;
   tlbtap_entry_s readEntry;
   modport owner (input writeEn, input index, input writeEntry, output readEntry);
   modport user (output writeEn, output index, output writeEntry, input readEntry);
endinterface : tlbtap_array_if

// File: verilog/tlbtap_entry_array.sv
`timescale 1ns/1ps
module tlbtap_entry_array #(
   parameter int IDX_W = 4
) (
   input wire logic clk,
   input wire logic rst,
   tlbtap_array_if.owner arr
);
   import tlbtap_pkg::*;

   localparam int DEPTH = 2**IDX_W;

   tlbtap_entry_s mem_q [DEPTH];
   tlbtap_entry_s mem_d [DEPTH];

   always_comb begin
      mem_d = mem_q;
      if (arr.writeEn) begin
         mem_d[arr.index] = arr.writeEntry;
      end
   end

   // reset clears every valid bit so lookups never match garbage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
      end else begin
         mem_q <= mem_d;
      end
   end

   assign arr.readEntry = mem_q[arr.index];

   chk_readback_latest: assert property (@(posedge clk) disable iff (rst)
      arr.writeEn |=> (mem_q[$past(arr.index)] == $past(arr.writeEntry)))
      else $error("entry array did not keep the written entry");

endmodule : tlbtap_entry_array

// File: verilog/tlbtap_test_port.sv
`timescale 1ns/1ps
module tlbtap_test_port (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [tlbtap_pkg::HADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [tlbtap_pkg::HDATA_W-1:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [tlbtap_pkg::HDATA_W-1:0] hrdata
);
   import tlbtap_pkg::*;

   // bus pipeline state
   logic pendValid_q;
   logic pendValid_d;
   logic pendWrite_q;
   logic pendWrite_d;
   logic [DEC_W-1:0] pendAddr_q;
   logic [DEC_W-1:0] pendAddr_d;

   // test registers and sequencing
   logic [31:0] cmdReg_q;
   logic [31:0] cmdReg_d;
   logic [31:0] dataReg_q;
   logic [31:0] dataReg_d;
   tlbtap_state_e state_q;
   tlbtap_state_e state_d;

   logic addrTaken;
   logic dataDone;
   logic swWrCmd;
   logic swWrData;
   logic execActive;
   tlbtap_op_e op;
   logic [SET_W-1:0] setSel;
   logic setLegal;
   logic [L1_IDX_W-1:0] l1Index;
   logic [L2_IDX_W-1:0] l2Index;
   logic [PAGE_W-1:0] lookupAddr;
   tlbtap_entry_s newEntry;
   tlbtap_entry_s l1Entry;
   tlbtap_entry_s wayEntry [L2_WAYS];
   tlbtap_entry_s selEntry;
   logic l1We;
   logic [L2_WAYS-1:0] wayWe;
   logic l1Match;
   logic [L2_WAYS-1:0] wayMatch;
   logic [2:0] matchCount;
   logic [SET_W-1:0] matchWay;

   tlbtap_array_if #(.IDX_W(L1_IDX_W)) l1If ();
   tlbtap_array_if #(.IDX_W(L2_IDX_W)) l2If [L2_WAYS] ();

   // direct mapped: one index, one entry per index
   tlbtap_entry_array #(.IDX_W(L1_IDX_W)) tlbtap_entry_array_inst (
      .clk(ref_clk),
      .rst(sys_rst),
      .arr(l1If)
   );

   assign l1If.writeEn = l1We;
   assign l1If.index = l1Index;
   assign l1If.writeEntry = newEntry;
   assign l1Entry = l1If.readEntry;

   // six ways of 64 sets each
   generate
      for (genvar w = 0; w < L2_WAYS; w++) begin : g_way
         tlbtap_entry_array #(.IDX_W(L2_IDX_W)) tlbtap_entry_array_inst (
            .clk(ref_clk),
            .rst(sys_rst),
            .arr(l2If[w])
         );
         assign l2If[w].writeEn = wayWe[w];
         assign l2If[w].index = l2Index;
         assign l2If[w].writeEntry = newEntry;
         assign wayEntry[w] = l2If[w].readEntry;
      end
   endgenerate

   // bus slave: only the single test op can stall the bus
   assign addrTaken = hsel && hready && htrans[1];
   assign dataDone = pendValid_q && hreadyout;
   assign swWrCmd = dataDone && pendWrite_q && (pendAddr_q == OFS_CMD);
   assign swWrData = dataDone && pendWrite_q && (pendAddr_q == OFS_DATA);
   assign hreadyout = (state_q == ST_IDLE);
   assign hresp = HRESP_OKAY;

   always_comb begin
      pendValid_d = pendValid_q;
      pendWrite_d = pendWrite_q;
      pendAddr_d = pendAddr_q;
      if (hready) begin
         pendValid_d = addrTaken;
         if (addrTaken) begin
            pendWrite_d = hwrite;
            pendAddr_d = haddr[DEC_W-1:0];
         end
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pendValid_q <= 1'b0;
         pendWrite_q <= 1'b0;
         pendAddr_q <= 8'h00;
      end else begin
         pendValid_q <= pendValid_d;
         pendWrite_q <= pendWrite_d;
         pendAddr_q <= pendAddr_d;
      end
   end

   // unmapped offsets read as zero; registers are flops so the mux settles early
   always_comb begin
      hrdata = 32'h0000_0000;
      if (pendValid_q && !pendWrite_q) begin
         if (pendAddr_q == OFS_CMD) begin
            hrdata = cmdReg_q;
         end else if (pendAddr_q == OFS_DATA) begin
            hrdata = dataReg_q;
         end
      end
   end

   // operands of the pending op
   assign execActive = (state_q == ST_EXEC);
   assign op = tlbtap_decode(cmdReg_q[CMD_MSB:CMD_LSB]);
   assign setSel = dataReg_q[SET_MSB:SET_LSB];
   assign setLegal = (setSel <= L2_LAST_WAY);
   assign lookupAddr = cmdReg_q[LA_MSB:LA_LSB];
   assign l1Index = cmdReg_q[L1_IDX_MSB:LA_LSB];
   assign l2Index = cmdReg_q[L2_IDX_MSB:LA_LSB];

   // entry built from both registers, data register loaded first by software
   always_comb begin
      newEntry.linAddr = lookupAddr;
      newEntry.valid = cmdReg_q[CMD_VALID_BIT];
      newEntry.dirty = cmdReg_q[CMD_DIRTY_BIT];
      newEntry.globalPage = cmdReg_q[CMD_GLOBAL_BIT];
      newEntry.user = cmdReg_q[CMD_USER_BIT];
      newEntry.writeProt = cmdReg_q[CMD_WPROT_BIT];
      newEntry.accessed = cmdReg_q[CMD_ACC_BIT];
      newEntry.physAddr = dataReg_q[PA_MSB:PA_LSB];
      newEntry.cacheDis = dataReg_q[DAT_CD_BIT];
      newEntry.writeThru = dataReg_q[DAT_WT_BIT];
   end

   // write strobes; a set select of 6 or 7 writes nothing
   always_comb begin
      l1We = execActive && (op == OP_WR_L1);
      for (int w = 0; w < L2_WAYS; w++) begin
         wayWe[w] = execActive && (op == OP_WR_L2) && (setSel == SET_W'(w));
      end
   end

   // hit detection against the supplied linear address
   always_comb begin
      l1Match = l1Entry.valid && (l1Entry.linAddr == lookupAddr);
      matchCount = 3'h0;
      matchWay = 3'h0;
      selEntry = '0;
      for (int w = 0; w < L2_WAYS; w++) begin
         wayMatch[w] = wayEntry[w].valid && (wayEntry[w].linAddr == lookupAddr);
         matchCount = matchCount + 3'(wayMatch[w]);
         if (wayMatch[w]) begin
            matchWay = SET_W'(w);
         end
         if (setSel == SET_W'(w)) begin
            selEntry = wayEntry[w];
         end
      end
   end

   // register updates from software and from the test op
   always_comb begin
      cmdReg_d = cmdReg_q;
      dataReg_d = dataReg_q;
      state_d = state_q;
      if (swWrCmd) begin
         cmdReg_d = hwdata & CMD_WR_MASK;
         state_d = ST_EXEC;
      end
      if (swWrData) begin
         // hit fields stay status-only, software cannot forge them
         dataReg_d = (hwdata & DATA_WR_MASK) | (dataReg_q & ~DATA_WR_MASK);
      end
      if (execActive) begin
         state_d = ST_IDLE;
         unique case (op)
            OP_WR_L1, OP_WR_L2: begin
               dataReg_d = dataReg_q;
            end
            OP_RD_L1: begin
               dataReg_d[L1_HIT_BIT] = l1Match;
               if (l1Match) begin
                  cmdReg_d[LA_MSB:LA_LSB] = l1Entry.linAddr;
                  cmdReg_d[CMD_VALID_BIT] = l1Entry.valid;
                  cmdReg_d[CMD_DIRTY_BIT] = l1Entry.dirty;
                  cmdReg_d[CMD_GLOBAL_BIT] = l1Entry.globalPage;
                  cmdReg_d[CMD_USER_BIT] = l1Entry.user;
                  cmdReg_d[CMD_WPROT_BIT] = l1Entry.writeProt;
                  cmdReg_d[CMD_ACC_BIT] = l1Entry.accessed;
                  dataReg_d[PA_MSB:PA_LSB] = l1Entry.physAddr;
                  dataReg_d[DAT_CD_BIT] = l1Entry.cacheDis;
                  dataReg_d[DAT_WT_BIT] = l1Entry.writeThru;
               end
            end
            OP_RD_L2: begin
               dataReg_d[L2_HIT_BIT] = (matchCount == 3'h1);
               dataReg_d[HIT_WAY_MSB:HIT_WAY_LSB] = (matchCount == 3'h1) ? matchWay : 3'h0;
               // fields move only on a single match and a legal set select
               if ((matchCount == 3'h1) && setLegal) begin
                  cmdReg_d[LA_MSB:LA_LSB] = selEntry.linAddr;
                  cmdReg_d[CMD_VALID_BIT] = selEntry.valid;
                  cmdReg_d[CMD_DIRTY_BIT] = selEntry.dirty;
                  cmdReg_d[CMD_GLOBAL_BIT] = selEntry.globalPage;
                  cmdReg_d[CMD_USER_BIT] = selEntry.user;
                  cmdReg_d[CMD_WPROT_BIT] = selEntry.writeProt;
                  cmdReg_d[CMD_ACC_BIT] = selEntry.accessed;
                  dataReg_d[PA_MSB:PA_LSB] = selEntry.physAddr;
                  dataReg_d[DAT_CD_BIT] = selEntry.cacheDis;
                  dataReg_d[DAT_WT_BIT] = selEntry.writeThru;
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cmdReg_q <= CMD_RST;
         dataReg_q <= DATA_RST;
         state_q <= ST_IDLE;
      end else begin
         cmdReg_q <= cmdReg_d;
         dataReg_q <= dataReg_d;
         state_q <= state_d;
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   chk_cmd_starts_op: assert property (
      swWrCmd |=> (state_q == ST_EXEC) ##1 (state_q == ST_IDLE))
      else $error("command write did not run exactly one test op");

   chk_l1_write_index: assert property (
      (execActive && (op == OP_WR_L1)) |-> (l1We && (l1Index == cmdReg_q[15:12]) && (wayWe == 6'h00)))
      else $error("first-level write used wrong index or touched second level");

   chk_l2_write_way: assert property (
      (execActive && (op == OP_WR_L2) && setLegal) |-> ((wayWe == (6'h01 << setSel)) && !l1We))
      else $error("second-level write did not hit the selected way only");

   chk_write_keeps_hits: assert property (
      (execActive && ((op == OP_WR_L1) || (op == OP_WR_L2))) |=> $stable(dataReg_q[6:0]))
      else $error("write op disturbed hit status");

   chk_l1_hit_flag: assert property (
      (execActive && (op == OP_RD_L1)) |=> (dataReg_q[5] == $past(l1Match)))
      else $error("first-level hit flag wrong after read");

   chk_l2_hit_flag: assert property (
      (execActive && (op == OP_RD_L2)) |=> (dataReg_q[4] == ($past(matchCount) == 3'h1)))
      else $error("second-level hit flag wrong after read");

   chk_hit_set_value: assert property (
      (execActive && (op == OP_RD_L2) && (matchCount == 3'h1)) |=> ((dataReg_q[2:0] == $past(matchWay))
         && (dataReg_q[2:0] <= 3'h5)))
      else $error("hit-set field does not name the matching way");

   chk_fields_unique: assert property (
      (execActive && (op == OP_RD_L2) && (matchCount != 3'h1)) |=> ($stable(cmdReg_q) && $stable(dataReg_q[31:10])))
      else $error("fields changed without a single match");

   chk_l1_read_loads: assert property (
      (execActive && (op == OP_RD_L1) && l1Match) |=> (dataReg_q[31:12] == $past(l1Entry.physAddr)))
      else $error("first-level read did not load physical page");

   chk_l2_read_loads: assert property (
      (execActive && (op == OP_RD_L2) && (matchCount == 3'h1) && setLegal) |=>
         ((cmdReg_q[31:12] == $past(selEntry.linAddr)) && (dataReg_q[31:12] == $past(selEntry.physAddr))))
      else $error("second-level read did not load the selected way");

   // a miss must leave every field alone, only the hit flag drops
   chk_l1_miss_keeps: assert property (
      (execActive && (op == OP_RD_L1) && !l1Match) |=> ($stable(cmdReg_q) && $stable(dataReg_q[31:6])))
      else $error("first-level miss changed register fields");

   chk_l1_read_keeps_l2: assert property (
      (execActive && (op == OP_RD_L1)) |=> $stable(dataReg_q[4:0]))
      else $error("first-level read disturbed second-level status");

   chk_l2_read_keeps_l1: assert property (
      (execActive && (op == OP_RD_L2)) |=> $stable(dataReg_q[5]))
      else $error("second-level read disturbed first-level hit flag");

   chk_cmd_write_mask: assert property (
      swWrCmd |=> (cmdReg_q == ($past(hwdata) & CMD_WR_MASK)))
      else $error("command register did not take the written fields");

   chk_data_write_split: assert property (
      swWrData |=> ((dataReg_q[31:7] == $past(hwdata[31:7])) && $stable(dataReg_q[6:0])))
      else $error("data register write touched status or lost fields");

   // entry stays addressed one cycle on, since the stall blocks software writes
   chk_write_allocates: assert property (
      (execActive && (op == OP_WR_L1)) |=> ((l1Entry.linAddr == $past(lookupAddr))
         && (l1Entry.valid == $past(cmdReg_q[CMD_VALID_BIT]))))
      else $error("first-level write did not allocate the entry");

   chk_bus_stall: assert property (
      swWrCmd |=> !hreadyout ##1 hreadyout)
      else $error("bus stall after command write is not one cycle");

   cov_l1_hit: cover property (execActive && (op == OP_RD_L1) && l1Match);
   cov_l2_hit_last_way: cover property (execActive && (op == OP_RD_L2) && (matchCount == 3'h1) && (matchWay == 3'h5));
   cov_l2_write: cover property (execActive && (op == OP_WR_L2) && setLegal);
   cov_port_y_read: cover property (execActive && cmdReg_q[CMD_PORT_BIT] && cmdReg_q[CMD_RD_BIT]);
   cov_l2_multi_match: cover property (execActive && (op == OP_RD_L2) && (matchCount > 3'h1));

endmodule : tlbtap_test_port

// File: tb/tlbtap_test_port_test.sv
`timescale 1ns/1ps
module tlbtap_test_port_test;
   import tlbtap_pkg::*;
   localparam logic [31:0] cmdAddr = {24'h00_0000, OFS_CMD};
   localparam logic [31:0] dataAddr = {24'h00_0000, OFS_DATA};
   localparam logic [31:0] holeAddr = 32'h0000_0008;
   localparam logic [31:0] allOnes = 32'hFFFF_FFFF;
   localparam logic [31:0] noHitWay = 32'hFFFF_FFF8;
   logic refClk = 1'b0;
   logic sysRst = 1'b1;
   logic hsel = 1'b1;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   int mismatches = 0;
   int compares = 0;

   tlbtap_test_port tlbtap_test_port_inst (
      .ref_clk(refClk),
      .sys_rst(sysRst),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hreadyout),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata)
   );

   always #25 refClk = ~refClk;

   task automatic check(input logic [31:0] seen, input logic [31:0] expected);
      compares++;
      if (seen !== expected) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, expected);
      end
   endtask : check

   // sample at the falling edge: only flops move at the rising edge, so this equals the rising-edge view
   // no local limit: only the watchdog ends a wait
   task automatic wait_ready(output logic [31:0] rd);
      @(negedge refClk);
      while (hreadyout !== 1'b1) begin
         @(negedge refClk);
      end
      rd = hrdata;
      @(posedge refClk);
   endtask : wait_ready

   task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdat, output logic [31:0] rd);
      logic [31:0] unused;
      htrans <= HTRANS_NONSEQ_BIT_SET;
      haddr <= addr;
      hwrite <= wr;
      wait_ready(unused);
      htrans <= 2'h0;
      hwdata <= wdat;
      wait_ready(rd);
   endtask : xfer

   task automatic rd_chk(input logic [31:0] addr, input logic [31:0] expected, input logic [31:0] msk);
      logic [31:0] v;
      xfer(1'b0, addr, 32'h0000_0000, v);
      check(v & msk, expected & msk);
      check({31'h0000_0000, hresp}, {31'h0000_0000, HRESP_OKAY});
   endtask : rd_chk

   // data first, then command: the command write launches the array operation
   task automatic op(input logic [31:0] dat, input logic [31:0] cmd, input logic [31:0] expCmd,
                     input logic [31:0] expDat, input logic [31:0] msk = allOnes);
      logic [31:0] v;
      xfer(1'b1, dataAddr, dat, v);
      xfer(1'b1, cmdAddr, cmd, v);
      @(negedge refClk);
      check({31'h0000_0000, hreadyout}, 32'h0000_0000);
      @(negedge refClk);
      check({31'h0000_0000, hreadyout}, 32'h0000_0001);
      @(posedge refClk);
      rd_chk(cmdAddr, expCmd, allOnes);
      rd_chk(dataAddr, expDat, msk);
   endtask : op

   task automatic end_sim;
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim

   initial begin
      repeat (20000) @(posedge refClk);
      mismatches++;
      end_sim();
   end

   initial begin
      logic [31:0] v;
      repeat (4) @(posedge refClk);
      sysRst <= 1'b0;
      rd_chk(cmdAddr, CMD_RST, allOnes);
      rd_chk(dataAddr, DATA_RST, allOnes);
      // unmapped place: write dropped, reads as zero
      xfer(1'b1, holeAddr, allOnes, v);
      rd_chk(holeAddr, 32'h0000_0000, allOnes);
      rd_chk(cmdAddr, 32'h0000_0000, allOnes);
      // all fields set, command 111 on an empty array: nothing matches
      op(allOnes, allOnes, 32'hFFFF_FF67, 32'hFFFF_FF80);
      // first-level writes with both spellings of x00
      op(32'hABCD_E800, 32'h1234_5D60, 32'h1234_5D60, 32'hABCD_E800);
      op(32'h5555_5400, 32'h0BEE_F844, 32'h0BEE_F844, 32'h5555_5400);
      // read back through port X and port Y
      op(32'h0000_0000, 32'h1234_5002, 32'h1234_5D62, 32'hABCD_E820);
      op(32'h0000_0000, 32'h1234_5006, 32'h1234_5D66, 32'hABCD_E820);
      op(32'h0000_0000, 32'h0BEE_F002, 32'h0BEE_F842, 32'h5555_5420);
      // same index, other page: direct mapped, so the old page is gone
      op(32'h2222_2000, 32'h5432_5800, 32'h5432_5800, 32'h2222_2020);
      op(32'h0000_0000, 32'h1234_5002, 32'h1234_5002, 32'h0000_0000);
      op(32'h0000_0000, 32'h5432_5002, 32'h5432_5802, 32'h2222_2020);
      // clear valid bit invalidates the entry
      op(32'h0000_0000, 32'h5432_5000, 32'h5432_5000, 32'h0000_0020);
      op(32'h0000_0000, 32'h5432_5002, 32'h5432_5002, 32'h0000_0000);
      // second level: two ways of one set index, both spellings of x01
      op(32'h1111_1580, 32'h2A03_FA01, 32'h2A03_FA01, 32'h1111_1580);
      op(32'h3333_3800, 32'h0007_F805, 32'h0007_F805, 32'h3333_3800);
      op(32'h0000_0180, 32'h2A03_F003, 32'h2A03_FA03, 32'h1111_1593);
      op(32'h0000_0000, 32'h0007_F007, 32'h0007_F807, 32'h3333_3810);
      // last way, same page as way 3: hit flags survive the write
      op(32'h4444_4280, 32'h2A03_F801, 32'h2A03_F801, 32'h4444_4290);
      // two ways match: no update, no hit, hit-set unchecked; then way 3 invalidated and way 5 hits alone
      op(32'h0000_0280, 32'h2A03_F003, 32'h2A03_F003, 32'h0000_0280, noHitWay);
      op(32'h0000_0180, 32'h2A03_F001, 32'h2A03_F001, 32'h0000_0180, noHitWay);
      op(32'h0000_0280, 32'h2A03_F003, 32'h2A03_F803, 32'h4444_4295);
      end_sim();
   end
endmodule : tlbtap_test_port_test
